// ===== bench/cmd_host_monitor.sv
// Concurrent checks on the command builder's ports
`timescale 1ns/1ps
module cmd_host_monitor
  import cmd_pkg::*;
(
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  // Request side
  input wire logic       i_req_valid,
  input wire logic       o_req_ready,
  input wire cmd_req_t   i_req,
  input wire logic       i_blank_pad,
  // Result
  input wire logic       o_done,
  input wire logic       o_error,
  input wire err_t       o_error_code,
  // Character stream
  input wire logic       o_tx_valid,
  input wire logic       i_tx_ready,
  input wire logic [7:0] o_tx_data
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  logic       take;
  logic [7:0] first_exp;
  assign take = i_req_valid && o_req_ready;

  // Command letter kept because the request bus may change after the take
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      first_exp <= 8'h00;
    else if (take)
      first_exp <= (i_req.cmd == CMD_WORD_READ) ? CH_Q : CH_J;
  end

  sequence s_accept;
    take && !o_tx_valid ##1 !o_error;
  endsequence
  sequence s_cnt_err;
    o_error && o_error_code == ERR_COUNT;
  endsequence

  property p_err_cause;
    o_error |-> $past(take);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("reject pulse without a taken request");
  property p_busy;
    take |=> (o_error || !o_req_ready);
  endproperty
  a_busy: assert property (p_busy)
    else $error("builder still ready after accepting");
  property p_first_char;
    s_accept |-> ##[0:2] (o_tx_valid && o_tx_data == first_exp);
  endproperty
  a_first_char: assert property (p_first_char)
    else $error("wrong first command character");
  property p_done_late;
    take |=> (!o_done) [*8];
  endproperty
  a_done_late: assert property (p_done_late)
    else $error("done before the header was sent");
  property p_bitread_cnt;
    take && i_req.cmd == CMD_BIT_READ && i_req.dev == DEV_INPUT &&
      (i_req.count == 0 || i_req.count > MAX_BIT_READ) |=> s_cnt_err;
  endproperty
  a_bitread_cnt: assert property (p_bitread_cnt)
    else $error("bad bit read count accepted");
  property p_wbit_cnt;
    take && i_req.cmd == CMD_WORD_READ && i_req.dev == DEV_INPUT &&
      i_req.count > MAX_WORD_BITDV |=> s_cnt_err;
  endproperty
  a_wbit_cnt: assert property (p_wbit_cnt)
    else $error("word read of bits over limit accepted");
  property p_wwrd_cnt;
    take && i_req.cmd == CMD_WORD_READ && i_req.dev == DEV_DATA_REG &&
      i_req.count > MAX_WORD_WRDDV |=> s_cnt_err;
  endproperty
  a_wwrd_cnt: assert property (p_wwrd_cnt)
    else $error("word read over limit accepted");
  property p_write_cnt;
    take && i_req.cmd == CMD_BIT_WRITE && i_req.dev == DEV_INTERNAL &&
      i_req.count > MAX_BIT_WRITE |=> s_cnt_err;
  endproperty
  a_write_cnt: assert property (p_write_cnt)
    else $error("bit write over limit accepted");
  property p_align;
    take && i_req.cmd == CMD_WORD_READ && i_req.dev == DEV_INTERNAL &&
      i_req.count == 1 && i_req.number[3:0] != 0
      |=> o_error && o_error_code == ERR_ALIGN;
  endproperty
  a_align: assert property (p_align)
    else $error("unaligned word head accepted");
  property p_range;
    take && i_req.cmd == CMD_BIT_READ && i_req.dev == DEV_LATCH &&
      i_req.count == 1 && i_req.number > MAX_RELAY
      |=> o_error && o_error_code == ERR_RANGE;
  endproperty
  a_range: assert property (p_range)
    else $error("relay number above limit accepted");
  property p_accept;
    take && i_req.cmd == CMD_BIT_READ && i_req.dev == DEV_STEP &&
      i_req.count == 1 && i_req.number <= MAX_RELAY |=> !o_error;
  endproperty
  a_accept: assert property (p_accept)
    else $error("legal relay read rejected");
endmodule

bind cmd_host cmd_host_monitor i_mon (
  .i_ref_clk    (i_ref_clk),
  .i_rstn       (i_rstn),
  .i_req_valid  (i_req_valid),
  .o_req_ready  (o_req_ready),
  .i_req        (i_req),
  .i_blank_pad  (i_blank_pad),
  .o_done       (o_done),
  .o_error      (o_error),
  .o_error_code (o_error_code),
  .o_tx_valid   (o_tx_valid),
  .i_tx_ready   (i_tx_ready),
  .o_tx_data    (o_tx_data)
);

// ===== bench/link_model.sv
// Link side model: collects command characters, stalls on demand
`timescale 1ns/1ps
module link_rx
  import cmd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_stall,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic [7:0] i_tx_data
);
  logic [7:0] rx_q[$];
  logic [3:0] beat;

  // Slow mode takes one char in 16 so the builder's FIFO fills up
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_tx_ready <= 1'b0;
      beat       <= 4'h0;
    end
    else
    begin
      if (i_tx_valid && o_tx_ready)
        rx_q.push_back(i_tx_data);
      beat       <= beat + 4'h1;
      o_tx_ready <= !i_stall || (beat == 4'hF);
    end
  end

  function automatic int digit(input logic [7:0] c);
    if (c == CH_BLANK)
      return 0;
    return (c >= CH_A) ? int'(c) - 55 : int'(c) - 48;
  endfunction

  // Count follows two command chars and the seven-char designation
  function automatic int count_of();
    int v;
    v = digit(rx_q[9]) * 16 + digit(rx_q[10]);
    return (v == 0) ? 256 : v;
  endfunction
endmodule

// ===== bench/tb.sv
// Self-checking testbench for the command builder
`timescale 1ns/1ps
module tb;
  import cmd_pkg::*;
  typedef logic [7:0] chars_t[$];
  logic       i_ref_clk = 1'b0;
  logic       i_rstn;
  logic       req_valid;
  logic       req_ready;
  cmd_req_t   req;
  logic       blank_pad;
  logic       done;
  logic       error;
  err_t       error_code;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_data;
  logic       stall;
  int         err_total;
  int         total_checks;

  always #50 i_ref_clk = ~i_ref_clk;

  // Narrowed write-only area makes the protect refusal reachable
  cmd_host #(.WR_ONLY_LO(16'h2338)) i_dut (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req),
    .i_blank_pad(blank_pad), .o_done(done), .o_error(error),
    .o_error_code(error_code), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .o_tx_data(tx_data));
  link_rx i_link (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_stall(stall),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data));

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_code(input err_t got, input err_t exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t reject code got %h want %h", $time, got, exp);
    end
  endtask

  // Ready only drops after a take, so ready seen low-edge means taken next
  task automatic send(input cmd_req_t r, input logic blank);
    @(negedge i_ref_clk);
    while (req_ready !== 1'b1)
      @(negedge i_ref_clk);
    req       = r;
    blank_pad = blank;
    req_valid = 1'b1;
    @(negedge i_ref_clk);
    req_valid = 1'b0;
  endtask

  task automatic run_ok(input cmd_req_t r, input logic blank,
                        input chars_t exp);
    int n;
    n = 0;
    i_link.rx_q.delete();
    send(r, blank);
    check_val(16'(error), 16'h0000, "reject flag");
    while (done !== 1'b1 && n < 4000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    check_val(16'(done), 16'h0001, "done pulse");
    while (i_link.rx_q.size() < exp.size() && n < 4000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    repeat (4) @(negedge i_ref_clk);
    check_val(16'(i_link.rx_q.size()), 16'(exp.size()), "length");
    check_val(16'(tx_valid), 16'h0000, "leftover");
    foreach (exp[k])
      check_val(16'(i_link.rx_q[k]), 16'(exp[k]), "char");
  endtask

  task automatic s_bit_read_full();
    stall = 1'b1;
    run_ok('{CMD_BIT_READ, DEV_INPUT, 14'h1ABC, 9'h100, 160'h0}, 1'b0,
      '{8'h4A, 8'h52, 8'h58, 8'h30, 8'h30, 8'h31, 8'h41, 8'h42, 8'h43,
        8'h30, 8'h30});
    check_val(16'(i_link.count_of()), 16'h0100, "count");
    stall = 1'b0;
  endtask

  task automatic s_timer_blank();
    run_ok('{CMD_WORD_READ, DEV_TMR_VALUE, 14'h07FF, 9'h001, 160'h0}, 1'b1,
      '{8'h51, 8'h52, 8'h54, 8'h4E, 8'h20, 8'h32, 8'h30, 8'h34, 8'h37,
        8'h30, 8'h31});
  endtask

  task automatic s_latch_write();
    stall = 1'b1;
    run_ok('{CMD_BIT_WRITE, DEV_LATCH, 14'h04D2, 9'h003, 160'h5}, 1'b0,
      '{8'h4A, 8'h57, 8'h4C, 8'h30, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
        8'h30, 8'h33, 8'h31, 8'h30, 8'h31});
    stall = 1'b0;
  endtask

  task automatic s_step_edge();
    run_ok('{CMD_BIT_READ, DEV_STEP, 14'h1FFF, 9'h001, 160'h0}, 1'b0,
      '{8'h4A, 8'h52, 8'h53, 8'h30, 8'h30, 8'h38, 8'h31, 8'h39, 8'h31,
        8'h30, 8'h31});
  endtask

  task automatic s_word_bits();
    run_ok('{CMD_WORD_READ, DEV_INTERNAL, 14'h1FF0, 9'h001, 160'h0}, 1'b0,
      '{8'h51, 8'h52, 8'h4D, 8'h30, 8'h30, 8'h38, 8'h31, 8'h37, 8'h36,
        8'h30, 8'h31});
  endtask

  task automatic s_refusals();
    cmd_req_t bad[9];
    err_t     code[9];
    bad = '{'{CMD_BIT_READ, DEV_INPUT, 14'h0010, 9'h000, 160'h0},
            '{CMD_BIT_READ, DEV_INPUT, 14'h0010, 9'h101, 160'h0},
            '{CMD_WORD_READ, DEV_INPUT, 14'h0010, 9'h021, 160'h0},
            '{CMD_WORD_READ, DEV_DATA_REG, 14'h0010, 9'h041, 160'h0},
            '{CMD_BIT_WRITE, DEV_INTERNAL, 14'h0010, 9'h0A1, 160'h0},
            '{CMD_WORD_READ, DEV_INTERNAL, 14'h0011, 9'h001, 160'h0},
            '{CMD_BIT_READ, DEV_LATCH, 14'h2000, 9'h001, 160'h0},
            '{CMD_BIT_READ, DEV_DATA_REG, 14'h0010, 9'h001, 160'h0},
            '{CMD_BIT_WRITE, DEV_SPEC_RELAY, 14'h2328, 9'h001, 160'h0}};
    code = '{ERR_COUNT, ERR_COUNT, ERR_COUNT, ERR_COUNT, ERR_COUNT,
             ERR_ALIGN, ERR_RANGE, ERR_KIND, ERR_PROTECT};
    i_link.rx_q.delete();
    foreach (bad[k])
    begin
      send(bad[k], 1'b0);
      check_val(16'(error), 16'h0001, "reject flag");
      check_code(error_code, code[k]);
    end
    repeat (4) @(negedge i_ref_clk);
    check_val(16'(i_link.rx_q.size()), 16'h0000, "sent");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    err_total    = 0;
    total_checks = 0;
    req_valid    = 1'b0;
    req          = '0;
    blank_pad    = 1'b0;
    stall        = 1'b0;
    i_rstn       = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    s_bit_read_full();
    s_timer_blank();
    s_latch_write();
    s_step_edge();
    s_word_bits();
    s_refusals();
    complete_run();
  end

  // Whole run needs well under 3000 cycles
  initial
  begin
    repeat (30000) @(posedge i_ref_clk);
    err_total++;
    $display("BAD %0t run did not finish", $time);
    complete_run();
  end
endmodule

// ===== core/char_fifo.sv
// Byte FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/1ps
module char_fifo
  import cmd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign o_in_ready  = (fill != (AW+1)'(DEPTH));
  assign o_out_valid = (fill != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        fill <= fill + 1'b1;
      end
      else if (pop && !push)
      begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

// ===== core/cmd_host.sv
// Host-side builder of device memory batch read/write command bodies
// ******************************************************
// Summary of operation
// R01: Every device designation goes out as exactly seven ASCII characters.
// R02: Device accepts blanks for leading zeros of the number part.
// R03: One type char plus six digits; timers and counters use two plus five.
// R04: Input, output, link relay and link register numbers are hexadecimal.
// R05: Relays, registers, timers, counters are decimal within limits.
// R06: Point count sent as two hex ASCII characters within command limit.
// R07: Count field 00 stands for 256 points.
// R08: Word-unit bit device head is multiple of 16, specials 9000 plus.
// R09: Internal, latch and step relay codes reach the same storage.
// R10: Special relay writes stay inside the write-only area.
// R11: Only numbers valid for both command set and target are used.
// R12: Word read of bit devices: 1 to 32 words, end within maximum.
// R13: Each word-unit point covers sixteen consecutive bit devices.
// R14: Word read of bit devices answers alike for both variants.
// R15: Word device batch read: 1 to 64 points, end within maximum.
// R16: Bit batch write: 1 to 160 points, end within maximum.
// R17: Count kept within what one communication cycle can process.
// R18: Device rejects bad commands and leaves memory unchanged.
// ******************************************************
`timescale 1ns/1ps
module cmd_host
  import cmd_pkg::*;
#(
  parameter bit          EXT_LINK   = 1'b1,
  parameter logic [15:0] WR_ONLY_LO = SPECIAL_LO,
  parameter logic [15:0] WR_ONLY_HI = SPECIAL_HI,
  parameter int          FIFO_DEPTH = 8
)
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // Request from user logic
  input  wire logic       i_req_valid,
  output logic            o_req_ready,
  input  wire cmd_req_t   i_req,
  input  wire logic       i_blank_pad,
  // Result
  output logic            o_done,
  output logic            o_error,
  output err_t            o_error_code,
  // Character stream toward the link
  output logic            o_tx_valid,
  input  wire logic       i_tx_ready,
  output logic [7:0]      o_tx_data
);

  // ******************************************************
  // Device table
  // ******************************************************
  function automatic dev_info_t dev_info(input dev_t d);
    dev_info_t r;
    r = '{c1: 8'h00, c2: 8'h00, two: 1'b0, hex: 1'b0,
          is_bit: 1'b1, lo: 16'h0000, hi: MAX_RELAY};
    case (d)
      DEV_INPUT:
      begin
        r.c1  = 8'h58;
        r.hex = 1'b1;  // see R04
        r.hi  = EXT_LINK ? MAX_XY_EXT : MAX_XY_STD;
      end
      DEV_OUTPUT:
      begin
        r.c1  = 8'h59;
        r.hex = 1'b1;  // see R04
        r.hi  = EXT_LINK ? MAX_XY_EXT : MAX_XY_STD;
      end
      // Same storage whatever code is used; limits are shared too
      DEV_INTERNAL: r.c1 = 8'h4D;  // see R09
      DEV_LATCH:    r.c1 = 8'h4C;  // see R09
      DEV_STEP:     r.c1 = 8'h53;  // see R09
      DEV_LINK_RELAY:
      begin
        r.c1  = 8'h42;
        r.hex = 1'b1;  // see R04
        r.hi  = EXT_LINK ? MAX_LINK_EXT : MAX_LINK_STD;
      end
      DEV_ANNUNC:
      begin
        r.c1 = 8'h46;
        r.hi = MAX_ANN;  // see R05
      end
      DEV_SPEC_RELAY:
      begin
        r.c1 = 8'h4D;
        r.lo = SPECIAL_LO;  // see R05
        r.hi = SPECIAL_HI;
      end
      DEV_TMR_CONT, DEV_TMR_COIL, DEV_TMR_VALUE:
      begin
        r.c1  = 8'h54;
        r.two = 1'b1;  // see R03
        r.c2  = (d == DEV_TMR_CONT) ? 8'h53 :
                (d == DEV_TMR_COIL) ? 8'h43 : 8'h4E;
        r.is_bit = (d != DEV_TMR_VALUE);
        r.hi  = MAX_TIMER;  // see R05
      end
      DEV_CNT_CONT, DEV_CNT_COIL, DEV_CNT_VALUE:
      begin
        r.c1  = 8'h43;
        r.two = 1'b1;  // see R03
        r.c2  = (d == DEV_CNT_CONT) ? 8'h53 :
                (d == DEV_CNT_COIL) ? 8'h43 : 8'h4E;
        r.is_bit = (d != DEV_CNT_VALUE);
        r.hi  = MAX_COUNTER;  // see R05
      end
      DEV_DATA_REG:
      begin
        r.c1     = 8'h44;
        r.is_bit = 1'b0;
        r.hi     = EXT_LINK ? MAX_DATA_EXT : MAX_DATA_STD;
      end
      DEV_LINK_REG:
      begin
        r.c1     = 8'h57;
        r.hex    = 1'b1;  // see R04
        r.is_bit = 1'b0;
        r.hi     = EXT_LINK ? MAX_LINK_EXT : MAX_LINK_STD;
      end
      DEV_FILE_REG:
      begin
        r.c1     = 8'h52;
        r.is_bit = 1'b0;
      end
      DEV_SPEC_REG:
      begin
        r.c1     = 8'h44;
        r.is_bit = 1'b0;
        r.lo     = SPECIAL_LO;  // see R05
        r.hi     = SPECIAL_HI;
      end
      default: r.c1 = 8'h00;
    endcase
    return r;
  endfunction

  // Binary to four BCD digits by shift-and-add
  function automatic logic [15:0] to_bcd(input logic [NUM_W-1:0] b);
    logic [15:0] bcd;
    bcd = 16'h0000;
    for (int i = NUM_W-1; i >= 0; i--)
    begin
      for (int j = 0; j < 4; j++)
      begin
        if (bcd[j*4 +: 4] > 4'h4)
        begin
          bcd[j*4 +: 4] = bcd[j*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[14:0], b[i]};
    end
    return bcd;
  endfunction

  function automatic logic [7:0] nib_char(input logic [3:0] n);
    return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A + {4'h0, n - 4'hA};
  endfunction

  // ******************************************************
  // Request checking
  // ******************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10
  } state_t;

  state_t           state;
  dev_info_t        info;
  logic [15:0]      head;
  logic [15:0]      last;
  logic [8:0]       cnt_max;
  logic             word_of_bits;
  err_t             next_err;
  logic [15:0]      digits;
  logic [7:0]       desig [DESIG_LEN];
  logic [7:0]       hdr [HDR_LEN];
  logic [WDATA_W-1:0] wdata;
  logic [8:0]       data_cnt;
  logic [3:0]       hdr_idx;
  logic [7:0]       data_idx;
  logic             fifo_ready;
  logic             push;
  logic [7:0]       push_byte;
  logic             take;

  assign info         = dev_info(i_req.dev);
  assign head         = {2'b00, i_req.number};
  assign word_of_bits = (i_req.cmd == CMD_WORD_READ) && info.is_bit;

  always_comb
  begin
    if (word_of_bits)
    begin
      last    = head + {i_req.count[7:0], 4'h0} - 16'h0001;  // see R12, R13
      cnt_max = MAX_WORD_BITDV;  // see R12
    end
    else
    begin
      last    = head + {7'h00, i_req.count} - 16'h0001;
      case (i_req.cmd)
        CMD_BIT_READ:  cnt_max = MAX_BIT_READ;  // see R17
        CMD_WORD_READ: cnt_max = MAX_WORD_WRDDV;  // see R15
        CMD_BIT_WRITE: cnt_max = MAX_BIT_WRITE;  // see R16
        default:       cnt_max = 9'h000;
      endcase
    end
  end

  // Checks run before any character leaves, so nothing bad is sent
  always_comb
  begin
    next_err = ERR_NONE;
    if (i_req.cmd != CMD_WORD_READ && !info.is_bit)
    begin
      next_err = ERR_KIND;
    end
    else if (i_req.count == 9'h000 || i_req.count > cnt_max)
    begin
      next_err = ERR_COUNT;  // see R06, R12, R15, R16, R17
    end
    else if (word_of_bits && ((head - info.lo) & 16'h000F) != 16'h0000)
    begin
      next_err = ERR_ALIGN;  // see R08
    end
    else if (head < info.lo || last > info.hi)
    begin
      next_err = ERR_RANGE;  // see R11, R12, R15, R16
    end
    else if (i_req.cmd == CMD_BIT_WRITE && i_req.dev == DEV_SPEC_RELAY &&
             (head < WR_ONLY_LO || last > WR_ONLY_HI))
    begin
      next_err = ERR_PROTECT;  // see R10
    end
  end

  // ******************************************************
  // Designation and header assembly
  // ******************************************************
  assign digits = info.hex ? {2'b00, i_req.number} : to_bcd(i_req.number);

  always_comb
  begin
    logic lead;
    lead = i_blank_pad;
    desig[0] = info.c1;
    desig[1] = info.two ? info.c2 : CH_ZERO;  // see R03
    desig[2] = CH_ZERO;
    for (int k = 0; k < 4; k++)
    begin
      desig[3+k] = nib_char(digits[(3-k)*4 +: 4]);
    end
    // Blank leading zeros; the final digit always stays visible
    for (int k = 1; k < DESIG_LEN-1; k++)
    begin
      if (!(k == 1 && info.two))
      begin
        if (lead && desig[k] == CH_ZERO)
        begin
          desig[k] = CH_BLANK;  // see R02
        end
        else
        begin
          lead = 1'b0;
        end
      end
    end
  end

  assign take = i_req_valid && o_req_ready;

  // ******************************************************
  // Command latch
  // ******************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int k = 0; k < HDR_LEN; k++)
      begin
        hdr[k] <= 8'h00;
      end
      wdata    <= '0;
      data_cnt <= 9'h000;
    end
    else if (take && next_err == ERR_NONE)
    begin
      hdr[0] <= (i_req.cmd == CMD_WORD_READ) ? CH_Q : CH_J;
      hdr[1] <= (i_req.cmd == CMD_BIT_WRITE) ? CH_W : CH_R;  // see R14
      for (int k = 0; k < DESIG_LEN; k++)
      begin
        hdr[2+k] <= desig[k];  // see R01
      end
      // 256 points wraps to the two characters 00
      hdr[9]   <= nib_char(i_req.count[7:4]);  // see R06, R07
      hdr[10]  <= nib_char(i_req.count[3:0]);  // see R06, R07
      wdata    <= i_req.wdata;
      data_cnt <= (i_req.cmd == CMD_BIT_WRITE) ? i_req.count : 9'h000;
    end
  end

  // ******************************************************
  // Sequencer
  // ******************************************************
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state    <= ST_IDLE;
      hdr_idx  <= 4'h0;
      data_idx <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          hdr_idx  <= 4'h0;
          data_idx <= 8'h00;
          if (take && next_err == ERR_NONE)
          begin
            state <= ST_HDR;
          end
        end
        ST_HDR:
        begin
          if (fifo_ready)
          begin
            if (hdr_idx == 4'(HDR_LEN-1))
            begin
              state <= (data_cnt != 9'h000) ? ST_DATA : ST_IDLE;
            end
            hdr_idx <= hdr_idx + 4'h1;
          end
        end
        ST_DATA:
        begin
          if (fifo_ready)
          begin
            if ({1'b0, data_idx} == data_cnt - 9'h001)
            begin
              state <= ST_IDLE;
            end
            data_idx <= data_idx + 8'h01;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_done       <= 1'b0;
      o_error      <= 1'b0;
      o_error_code <= ERR_NONE;
    end
    else
    begin
      o_done  <= fifo_ready &&
                 ((state == ST_HDR && hdr_idx == 4'(HDR_LEN-1) &&
                   data_cnt == 9'h000) ||
                  (state == ST_DATA &&
                   {1'b0, data_idx} == data_cnt - 9'h001));
      o_error <= take && next_err != ERR_NONE;  // see R18
      if (take)
      begin
        o_error_code <= next_err;
      end
    end
  end

  assign o_req_ready = (state == ST_IDLE);
  assign push        = (state == ST_HDR) || (state == ST_DATA);
  assign push_byte   = (state == ST_HDR) ? hdr[hdr_idx] :
                       (wdata[data_idx] ? CH_ONE : CH_ZERO);

  // ******************************************************
  // Output buffer
  // ******************************************************
  // Link back-pressure stalls the sequencer through the buffer's ready
  char_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (push_byte),
    .o_out_valid (o_tx_valid),
    .i_out_ready (i_tx_ready),
    .o_out_data  (o_tx_data)
  );

endmodule

// ===== core/cmd_pkg.sv
// Shared types and constants for the device memory command builder
package cmd_pkg;

  // ******************************************************
  // Field sizes
  // ******************************************************
  localparam int DESIG_LEN  = 7;
  localparam int HDR_LEN    = 11;
  localparam int NUM_W      = 14;
  localparam int CNT_W      = 9;
  localparam int WDATA_W    = 160;
  localparam int WORD_BITS  = 16;

  // ******************************************************
  // Point count limits per command
  // ******************************************************
  localparam logic [8:0] MAX_BIT_READ   = 9'h100;
  localparam logic [8:0] MAX_WORD_BITDV = 9'h020;
  localparam logic [8:0] MAX_WORD_WRDDV = 9'h040;
  localparam logic [8:0] MAX_BIT_WRITE  = 9'h0A0;

  // ******************************************************
  // Device number limits
  // ******************************************************
  localparam logic [15:0] MAX_XY_EXT   = 16'h1FFF;
  localparam logic [15:0] MAX_XY_STD   = 16'h07FF;
  localparam logic [15:0] MAX_LINK_EXT = 16'h1FFF;
  localparam logic [15:0] MAX_LINK_STD = 16'h0FFF;
  localparam logic [15:0] MAX_DATA_EXT = 16'h1FFF;
  localparam logic [15:0] MAX_DATA_STD = 16'h17FF;
  localparam logic [15:0] MAX_RELAY    = 16'h1FFF;
  localparam logic [15:0] MAX_ANN      = 16'h07FF;
  localparam logic [15:0] MAX_TIMER    = 16'h07FF;
  localparam logic [15:0] MAX_COUNTER  = 16'h03FF;
  localparam logic [15:0] SPECIAL_LO   = 16'h2328;
  localparam logic [15:0] SPECIAL_HI   = 16'h2427;

  // ******************************************************
  // ASCII codes
  // ******************************************************
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_J     = 8'h4A;
  localparam logic [7:0] CH_Q     = 8'h51;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_W     = 8'h57;

  // ******************************************************
  // Enumerations and carriers
  // ******************************************************
  typedef enum logic [1:0] {
    CMD_BIT_READ  = 2'b00,
    CMD_WORD_READ = 2'b01,
    CMD_BIT_WRITE = 2'b10
  } cmd_t;

  typedef enum logic [4:0] {
    DEV_INPUT      = 5'b00000,
    DEV_OUTPUT     = 5'b00001,
    DEV_INTERNAL   = 5'b00010,
    DEV_LATCH      = 5'b00011,
    DEV_STEP       = 5'b00100,
    DEV_LINK_RELAY = 5'b00101,
    DEV_ANNUNC     = 5'b00110,
    DEV_SPEC_RELAY = 5'b00111,
    DEV_TMR_CONT   = 5'b01000,
    DEV_TMR_COIL   = 5'b01001,
    DEV_CNT_CONT   = 5'b01010,
    DEV_CNT_COIL   = 5'b01011,
    DEV_TMR_VALUE  = 5'b01100,
    DEV_CNT_VALUE  = 5'b01101,
    DEV_DATA_REG   = 5'b01110,
    DEV_LINK_REG   = 5'b01111,
    DEV_FILE_REG   = 5'b10000,
    DEV_SPEC_REG   = 5'b10001
  } dev_t;

  typedef enum logic [2:0] {
    ERR_NONE    = 3'b000,
    ERR_KIND    = 3'b001,
    ERR_COUNT   = 3'b010,
    ERR_ALIGN   = 3'b011,
    ERR_RANGE   = 3'b100,
    ERR_PROTECT = 3'b101
  } err_t;

  typedef struct packed {
    cmd_t                 cmd;
    dev_t                 dev;
    logic [NUM_W-1:0]     number;
    logic [CNT_W-1:0]     count;
    logic [WDATA_W-1:0]   wdata;
  } cmd_req_t;

  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic        two;
    logic        hex;
    logic        is_bit;
    logic [15:0] lo;
    logic [15:0] hi;
  } dev_info_t;

endpackage
